//--- src/cmf_pkg.sv
// constants shared by the message queue status and pointer block
package cmf_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned CMF_ADDR_W = 12;
  localparam int unsigned CMF_DATA_W = 32;
  localparam int unsigned CMF_STRB_W = 4;
  localparam int unsigned CMF_IDX_W = 5;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] CMF_OFS_CTRL = 12'h000;
  localparam logic [11:0] CMF_OFS_IRQ = 12'h004;
  localparam logic [11:0] CMF_OFS_SW_PTR = 12'h008;
  localparam logic [11:0] CMF_OFS_ENG_IDX = 12'h00c;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CMF_CTRL_DIR = 7;
  localparam int unsigned CMF_CTRL_ADV = 13;
  localparam int unsigned CMF_CTRL_DEPTH_LO = 16;

  // ---------------------------------------------------------------
  // interrupt register fields
  // ---------------------------------------------------------------
  localparam int unsigned CMF_BIT_TX_ROOM_EN = 26;
  localparam int unsigned CMF_BIT_TX_HALF_EN = 25;
  localparam int unsigned CMF_BIT_TX_DRAINED_EN = 24;
  localparam int unsigned CMF_BIT_RX_OVERRUN_EN = 19;
  localparam int unsigned CMF_BIT_RX_FILLED_EN = 18;
  localparam int unsigned CMF_BIT_RX_HALF_EN = 17;
  localparam int unsigned CMF_BIT_RX_PENDING_EN = 16;
  localparam int unsigned CMF_BIT_TX_ROOM = 10;
  localparam int unsigned CMF_BIT_TX_HALF = 9;
  localparam int unsigned CMF_BIT_TX_DRAINED = 8;
  localparam int unsigned CMF_BIT_RX_OVERRUN = 3;
  localparam int unsigned CMF_BIT_RX_FILLED = 2;
  localparam int unsigned CMF_BIT_RX_HALF = 1;
  localparam int unsigned CMF_BIT_RX_PENDING = 0;
  localparam int unsigned CMF_TX_EN_LO = 24;
  localparam int unsigned CMF_RX_EN_LO = 16;
  localparam int unsigned CMF_TX_FLAG_LO = 8;
  localparam int unsigned CMF_RX_FLAG_LO = 0;

  // ---------------------------------------------------------------
  // mode codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] CMF_MODE_CONFIG = 3'h4;
  localparam logic [2:0] CMF_EN3_RESET = 3'h0;
  localparam logic [3:0] CMF_EN4_RESET = 4'h0;
  localparam logic [4:0] CMF_DEPTH_RESET = 5'h00;
  localparam logic [1:0] CMF_ALIGN_ZERO = 2'h0;

endpackage : cmf_pkg

//--- src/cmf_ring_ptr.sv
// wrapping slot index for one end of a message queue
`timescale 1ns/1ps
module cmf_ring_ptr
  import cmf_pkg::*;
#(
  parameter int unsigned IDX_W = CMF_IDX_W
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic clear_in,
  input wire logic advance_in,
  input wire logic [IDX_W-1:0] depth_field_in,
  output logic [IDX_W-1:0] index_out
);

  // ---------------------------------------------------------------
  // index register
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] index_reg;
  logic [IDX_W-1:0] index_next;

  always_comb begin
    index_next = index_reg;
    if (clear_in) begin
      index_next = '0;
    end else if (advance_in) begin
      // last slot is the depth field value itself
      if (index_reg >= depth_field_in) begin
        index_next = '0;
      end else begin
        index_next = IDX_W'(index_reg + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      index_reg <= '0;
    end else begin
      index_reg <= index_next;
    end
  end

  assign index_out = index_reg;

endmodule // cmf_ring_ptr

//--- src/cmf_queue_status.sv
// status, interrupt enables and pointers of one message queue
`timescale 1ns/1ps
module cmf_queue_status
  import cmf_pkg::*;
#(
  parameter int unsigned IDX_W = CMF_IDX_W,
  parameter int unsigned MSG_BYTES = 16
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [CMF_ADDR_W-1:0] paddr_in,
  input wire logic [CMF_DATA_W-1:0] pwdata_in,
  input wire logic [CMF_STRB_W-1:0] pstrb_in,
  output logic [CMF_DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [2:0] current_op_mode_in,
  input wire logic [CMF_DATA_W-1:0] fifo_base_addr_in,
  input wire logic engine_rx_store_in,
  input wire logic engine_tx_sent_in,
  output logic [IDX_W-1:0] engine_slot_index_out,
  output logic queue_direction_sel_out,
  output logic [IDX_W-1:0] queue_depth_field_out,
  output logic rx_accept_out,
  output logic tx_pending_out,
  output logic queue_irq_out
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [CMF_DATA_W-1:0] lane_mask(
    input logic [CMF_STRB_W-1:0] strb
  );
    logic [CMF_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < CMF_STRB_W; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  function automatic logic [IDX_W:0] depth_of(
    input logic [IDX_W-1:0] field
  );
    return (IDX_W+1)'(field) + 1'b1;
  endfunction

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic setup_phase;
  logic wr_access;
  logic sel_ctrl;
  logic sel_irq;
  logic sel_sw_ptr;
  logic sel_eng_idx;
  logic addr_hit;
  logic [CMF_DATA_W-1:0] wmask;
  logic [CMF_DATA_W-1:0] wbits;
  logic config_mode;

  assign setup_phase = psel_in && !penable_in;
  assign wr_access = psel_in && penable_in && pwrite_in;
  assign sel_ctrl = (paddr_in == CMF_OFS_CTRL);
  assign sel_irq = (paddr_in == CMF_OFS_IRQ);
  assign sel_sw_ptr = (paddr_in == CMF_OFS_SW_PTR);
  assign sel_eng_idx = (paddr_in == CMF_OFS_ENG_IDX);
  assign addr_hit = sel_ctrl || sel_irq || sel_sw_ptr || sel_eng_idx;
  assign wmask = lane_mask(pstrb_in);
  assign wbits = pwdata_in & wmask;
  assign config_mode = (current_op_mode_in == CMF_MODE_CONFIG);

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic dir_tx_reg;
  logic [IDX_W-1:0] depth_field_reg;
  logic cfg_write;
  logic adv_req;

  // layout changes only in configuration mode, and restart the queue
  assign cfg_write = wr_access && sel_ctrl && config_mode;
  // advance bit is self-clearing: it only acts as a write pulse
  assign adv_req = wr_access && sel_ctrl && wbits[CMF_CTRL_ADV];

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dir_tx_reg <= 1'b0;
    end else if (cfg_write && wmask[CMF_CTRL_DIR]) begin
      dir_tx_reg <= pwdata_in[CMF_CTRL_DIR];
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      depth_field_reg <= CMF_DEPTH_RESET;
    end else if (cfg_write && wmask[CMF_CTRL_DEPTH_LO]) begin
      depth_field_reg <= pwdata_in[CMF_CTRL_DEPTH_LO +: IDX_W];
    end
  end

  // ---------------------------------------------------------------
  // occupancy
  // ---------------------------------------------------------------
  logic [IDX_W:0] count_reg;
  logic [IDX_W:0] depth;
  logic q_full;
  logic q_empty;
  logic sw_step;
  logic eng_step;
  logic cnt_inc;
  logic cnt_dec;
  logic overrun_evt;

  assign depth = depth_of(depth_field_reg);
  assign q_full = (count_reg >= depth);
  assign q_empty = (count_reg == '0);

  // transmit: software fills the head, engine drains
  // receive: engine fills, software drains the tail
  assign sw_step = adv_req && (dir_tx_reg ? !q_full : !q_empty);
  assign eng_step = dir_tx_reg ? (engine_tx_sent_in && !q_empty)
                               : (engine_rx_store_in && !q_full);
  assign cnt_inc = dir_tx_reg ? sw_step : eng_step;
  assign cnt_dec = dir_tx_reg ? eng_step : sw_step;
  assign overrun_evt = !dir_tx_reg && engine_rx_store_in && q_full;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_reg <= '0;
    end else if (cfg_write) begin
      count_reg <= '0;
    end else if (cnt_inc && !cnt_dec) begin
      count_reg <= (IDX_W+1)'(count_reg + 1'b1);
    end else if (cnt_dec && !cnt_inc) begin
      count_reg <= (IDX_W+1)'(count_reg - 1'b1);
    end
  end

  // ---------------------------------------------------------------
  // pointers
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] sw_index;
  logic [IDX_W-1:0] eng_index;

  cmf_ring_ptr #(
    .IDX_W(IDX_W)
  ) u_sw_ptr (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .clear_in(cfg_write),
    .advance_in(sw_step),
    .depth_field_in(depth_field_reg),
    .index_out(sw_index)
  );

  cmf_ring_ptr #(
    .IDX_W(IDX_W)
  ) u_eng_ptr (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .clear_in(cfg_write),
    .advance_in(eng_step),
    .depth_field_in(depth_field_reg),
    .index_out(eng_index)
  );

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic tx_room_flag;
  logic tx_half_flag;
  logic tx_drained_flag;
  logic rx_filled_flag;
  logic rx_half_flag;
  logic rx_pending_flag;
  logic [IDX_W+1:0] count_x2;
  logic [IDX_W+1:0] depth_wide;

  assign count_x2 = {count_reg, 1'b0};
  assign depth_wide = (IDX_W+2)'(depth);

  // level flags follow the occupancy, nothing latches
  assign tx_room_flag = dir_tx_reg && !q_full;
  assign tx_half_flag = dir_tx_reg && (count_x2 <= depth_wide);
  assign tx_drained_flag = dir_tx_reg && q_empty;
  assign rx_filled_flag = !dir_tx_reg && q_full;
  assign rx_half_flag = !dir_tx_reg && (count_x2 >= depth_wide);
  assign rx_pending_flag = !dir_tx_reg && !q_empty;

  // ---------------------------------------------------------------
  // interrupt register
  // ---------------------------------------------------------------
  logic [2:0] tx_en_reg;
  logic [3:0] rx_en_reg;
  logic overrun_reg;
  logic irq_write;

  assign irq_write = wr_access && sel_irq;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_en_reg <= CMF_EN3_RESET;
    end else if (irq_write && wmask[CMF_TX_EN_LO]) begin
      tx_en_reg <= pwdata_in[CMF_TX_EN_LO +: 3];
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_en_reg <= CMF_EN4_RESET;
    end else if (irq_write && wmask[CMF_RX_EN_LO]) begin
      rx_en_reg <= pwdata_in[CMF_RX_EN_LO +: 4];
    end
  end

  // a configuration write clears first; hardware set wins over an interrupt register write in the same cycle
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      overrun_reg <= 1'b0;
    end else if (cfg_write) begin
      overrun_reg <= 1'b0;
    end else if (overrun_evt) begin
      overrun_reg <= 1'b1;
    end else if (irq_write && wmask[CMF_BIT_RX_OVERRUN]) begin
      overrun_reg <= pwdata_in[CMF_BIT_RX_OVERRUN];
    end
  end

  logic rx_overrun_flag;
  logic [CMF_DATA_W-1:0] irq_word;

  assign rx_overrun_flag = !dir_tx_reg && overrun_reg;

  always_comb begin
    irq_word = '0;
    irq_word[CMF_BIT_TX_ROOM_EN] = tx_en_reg[2];
    irq_word[CMF_BIT_TX_HALF_EN] = tx_en_reg[1];
    irq_word[CMF_BIT_TX_DRAINED_EN] = tx_en_reg[0];
    irq_word[CMF_BIT_RX_OVERRUN_EN] = rx_en_reg[3];
    irq_word[CMF_BIT_RX_FILLED_EN] = rx_en_reg[2];
    irq_word[CMF_BIT_RX_HALF_EN] = rx_en_reg[1];
    irq_word[CMF_BIT_RX_PENDING_EN] = rx_en_reg[0];
    irq_word[CMF_BIT_TX_ROOM] = tx_room_flag;
    irq_word[CMF_BIT_TX_HALF] = tx_half_flag;
    irq_word[CMF_BIT_TX_DRAINED] = tx_drained_flag;
    irq_word[CMF_BIT_RX_OVERRUN] = rx_overrun_flag;
    irq_word[CMF_BIT_RX_FILLED] = rx_filled_flag;
    irq_word[CMF_BIT_RX_HALF] = rx_half_flag;
    irq_word[CMF_BIT_RX_PENDING] = rx_pending_flag;
  end

  // ---------------------------------------------------------------
  // interrupt request
  // ---------------------------------------------------------------
  logic [6:0] flag_vec;
  logic [6:0] en_vec;
  logic irq_reg;

  assign flag_vec = irq_word[CMF_RX_FLAG_LO +: 4] == 4'h0
                  ? {irq_word[CMF_TX_FLAG_LO +: 3], 4'h0}
                  : {irq_word[CMF_TX_FLAG_LO +: 3],
                     irq_word[CMF_RX_FLAG_LO +: 4]};
  assign en_vec = {tx_en_reg, rx_en_reg};

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flag_vec & en_vec);
    end
  end

  // ---------------------------------------------------------------
  // pointer words
  // ---------------------------------------------------------------
  logic [CMF_DATA_W-1:0] sw_addr;
  logic [CMF_DATA_W-1:0] sw_ptr_word;
  logic [CMF_DATA_W-1:0] eng_idx_word;

  // head when transmitting, tail when receiving: same software index
  assign sw_addr = CMF_DATA_W'(fifo_base_addr_in
                 + CMF_DATA_W'(sw_index) * CMF_DATA_W'(MSG_BYTES));
  assign sw_ptr_word = {sw_addr[CMF_DATA_W-1:2], CMF_ALIGN_ZERO};
  assign eng_idx_word = CMF_DATA_W'(eng_index);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [CMF_DATA_W-1:0] ctrl_word;
  logic [CMF_DATA_W-1:0] rdata_next;
  logic [CMF_DATA_W-1:0] rdata_reg;
  logic slverr_reg;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CMF_CTRL_DIR] = dir_tx_reg;
    ctrl_word[CMF_CTRL_DEPTH_LO +: IDX_W] = depth_field_reg;
  end

  always_comb begin
    rdata_next = '0;
    if (sel_ctrl) begin
      rdata_next = ctrl_word;
    end else if (sel_irq) begin
      rdata_next = irq_word;
    end else if (sel_sw_ptr) begin
      rdata_next = sw_ptr_word;
    end else if (sel_eng_idx) begin
      rdata_next = eng_idx_word;
    end
  end

  // answer is captured in the setup cycle, given with zero wait
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_reg <= '0;
    end else if (setup_phase) begin
      rdata_reg <= pwrite_in ? '0 : rdata_next;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slverr_reg <= 1'b0;
    end else if (setup_phase) begin
      slverr_reg <= !addr_hit;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_out = rdata_reg;
  assign pready_out = psel_in && penable_in;
  assign pslverr_out = psel_in && penable_in && slverr_reg;
  assign engine_slot_index_out = eng_index;
  assign queue_direction_sel_out = dir_tx_reg;
  assign queue_depth_field_out = depth_field_reg;
  assign rx_accept_out = !dir_tx_reg && !q_full;
  assign tx_pending_out = dir_tx_reg && !q_empty;
  assign queue_irq_out = irq_reg;

endmodule // cmf_queue_status

//--- test/cmf_queue_props.sv
// checker for the message queue status block ports
`timescale 1ns/1ps
module cmf_queue_props
  import cmf_pkg::*;
#(
  parameter int unsigned IDX_W = CMF_IDX_W
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [CMF_ADDR_W-1:0] paddr_in,
  input wire logic [CMF_DATA_W-1:0] prdata_out,
  input wire logic engine_rx_store_in,
  input wire logic engine_tx_sent_in,
  input wire logic [IDX_W-1:0] engine_slot_index_out,
  input wire logic queue_direction_sel_out,
  input wire logic [IDX_W-1:0] queue_depth_field_out,
  input wire logic rx_accept_out,
  input wire logic tx_pending_out
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] step_next;
  logic rd_acc;
  logic quiet;
  assign step_next = (engine_slot_index_out == queue_depth_field_out) ?
    '0 : engine_slot_index_out + 1'b1;
  assign rd_acc = psel_in & penable_in & ~pwrite_in;
  assign quiet = ~psel_in;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_accept_rx_only: assert property (
    rx_accept_out |-> !queue_direction_sel_out)
    else $error("receive accept seen in transmit queue");
  a_pending_tx_only: assert property (
    tx_pending_out |-> queue_direction_sel_out)
    else $error("transmit pending seen in receive queue");
  a_store_step: assert property (
    quiet && !queue_direction_sel_out && engine_rx_store_in && rx_accept_out
    |=> engine_slot_index_out == $past(step_next))
    else $error("store did not advance engine index");
  a_sent_step: assert property (
    quiet && queue_direction_sel_out && engine_tx_sent_in && tx_pending_out
    |=> engine_slot_index_out == $past(step_next))
    else $error("send did not advance engine index");
  a_full_drop: assert property (
    quiet && !queue_direction_sel_out && engine_rx_store_in && !rx_accept_out
    |=> $stable(engine_slot_index_out))
    else $error("store into full queue moved index");
  a_index_hold: assert property (
    quiet && !engine_rx_store_in && !engine_tx_sent_in
    |=> $stable(engine_slot_index_out))
    else $error("engine index moved without a strobe");
  a_ptr_aligned: assert property (
    rd_acc && paddr_in == CMF_OFS_SW_PTR |-> prdata_out[1:0] == 2'h0)
    else $error("pointer read not word aligned");
  a_irq_unused: assert property (
    rd_acc && paddr_in == CMF_OFS_IRQ |-> (prdata_out & 32'hf8f0_f8f0) == '0)
    else $error("unused interrupt register bits set");
  a_index_read: assert property (
    rd_acc && paddr_in == CMF_OFS_ENG_IDX
    |-> prdata_out == CMF_DATA_W'($past(engine_slot_index_out)))
    else $error("engine index read differs");
  a_rx_hides_tx: assert property (
    rd_acc && paddr_in == CMF_OFS_IRQ && !queue_direction_sel_out
    |-> prdata_out[CMF_TX_FLAG_LO +: 3] == 3'h0)
    else $error("transmit flags seen in receive queue");
  a_tx_hides_rx: assert property (
    rd_acc && paddr_in == CMF_OFS_IRQ && queue_direction_sel_out
    |-> prdata_out[CMF_RX_FLAG_LO +: 4] == 4'h0)
    else $error("receive flags seen in transmit queue");
endmodule // cmf_queue_props

//--- test/cmf_engine_model.sv
// protocol engine stand-in: one message strobe per kick
`timescale 1ns/1ps
module cmf_engine_model (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic kick_in,
  input wire logic queue_direction_sel_in,
  output logic engine_rx_store_out,
  output logic engine_tx_sent_out
);
  // strobe follows the queue direction, one cycle wide
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      engine_rx_store_out <= 1'b0;
      engine_tx_sent_out <= 1'b0;
    end else begin
      engine_rx_store_out <= kick_in & ~queue_direction_sel_in;
      engine_tx_sent_out <= kick_in & queue_direction_sel_in;
    end
  end
endmodule // cmf_engine_model

//--- test/tb_top.sv
// self-checking bench for the queue status block
`timescale 1ns/1ps
module tb_top;
  import cmf_pkg::*;
  typedef struct packed {
    logic [2:0] act;
    logic [11:0] flags;
    logic [4:0] eidx;
    logic [4:0] sidx;
  } cmf_row_s;
  localparam logic [31:0] EN = 32'h070f_0000;
  localparam logic [31:0] BASE = 32'h2000_0103;
  logic sys_clk_in, arst_n_in, psel, penable, pwrite, kick, errv;
  logic pready, pslverr, dir, irq, rx_st, tx_st, rx_acc, tx_pend;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, xv;
  logic [2:0] mode;
  logic [4:0] eidx, depth;
  int err_total, n_checks, cyc;
  cmf_row_s rows [0:16] = '{
    '{3'h0, 12'h000, 5'h0, 5'h0}, '{3'h2, 12'h001, 5'h1, 5'h0},
    '{3'h2, 12'h003, 5'h2, 5'h0}, '{3'h2, 12'h003, 5'h3, 5'h0},
    '{3'h2, 12'h007, 5'h0, 5'h0}, '{3'h2, 12'h00f, 5'h0, 5'h0},
    '{3'h3, 12'h00b, 5'h0, 5'h1}, '{3'h4, 12'h003, 5'h0, 5'h1},
    '{3'h1, 12'h700, 5'h0, 5'h0}, '{3'h3, 12'h600, 5'h0, 5'h1},
    '{3'h3, 12'h600, 5'h0, 5'h2}, '{3'h2, 12'h600, 5'h1, 5'h2},
    '{3'h3, 12'h600, 5'h1, 5'h3}, '{3'h3, 12'h400, 5'h1, 5'h0},
    '{3'h3, 12'h000, 5'h1, 5'h1}, '{3'h3, 12'h000, 5'h1, 5'h1},
    '{3'h2, 12'h400, 5'h2, 5'h1}};
  cmf_queue_status dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .current_op_mode_in(mode), .fifo_base_addr_in(BASE),
    .engine_rx_store_in(rx_st), .engine_tx_sent_in(tx_st),
    .engine_slot_index_out(eidx), .queue_direction_sel_out(dir),
    .queue_depth_field_out(depth), .rx_accept_out(rx_acc),
    .tx_pending_out(tx_pend), .queue_irq_out(irq));
  cmf_engine_model u_eng (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .kick_in(kick), .queue_direction_sel_in(dir),
    .engine_rx_store_out(rx_st), .engine_tx_sent_out(tx_st));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    @(posedge sys_clk_in);
    while (pready !== 1'b1) @(posedge sys_clk_in);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] ctrl);
    @(posedge sys_clk_in);
    mode <= CMF_MODE_CONFIG;
    apb(1'b1, CMF_OFS_CTRL, ctrl);
    mode <= 3'h0;
  endtask
  // ---------------------------------------------------------------
  // clock, timeout, sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    {psel, penable, pwrite, kick, arst_n_in} = '0;
    paddr = '0;
    pwdata = '0;
    mode = 3'h0;
    repeat (8) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    apb(1'b0, CMF_OFS_IRQ, 32'h0);
    chk("irq reset", rdv, 32'h0);
    apb(1'b1, CMF_OFS_IRQ, EN);
    foreach (rows[i]) begin
      case (rows[i].act)
        3'h0: cfg(32'h0003_0000);
        3'h1: cfg(32'h0003_0080);
        3'h2: begin
          @(posedge sys_clk_in);
          kick <= 1'b1;
          @(posedge sys_clk_in);
          kick <= 1'b0;
          repeat (2) @(posedge sys_clk_in);
        end
        3'h3: apb(1'b1, CMF_OFS_CTRL, 32'h0000_2000);
        default: apb(1'b1, CMF_OFS_IRQ, EN);
      endcase
      apb(1'b0, CMF_OFS_IRQ, 32'h0);
      xv = EN | 32'(rows[i].flags);
      chk("irq reg", rdv, xv);
      chk("irq out", 32'(irq), 32'(|rows[i].flags));
      apb(1'b0, CMF_OFS_ENG_IDX, 32'h0);
      chk("engine idx", rdv, 32'(rows[i].eidx));
      apb(1'b0, CMF_OFS_SW_PTR, 32'h0);
      xv = (BASE + 32'(rows[i].sidx) * 16) & 32'hffff_fffc;
      chk("sw ptr", rdv, xv);
    end
    chk("depth field", 32'(depth), 32'h3);
    chk("tx pending", 32'(tx_pend), 32'h1);
    chk("rx accept", 32'(rx_acc), 32'h0);
    apb(1'b0, CMF_OFS_CTRL, 32'h0);
    chk("ctrl read", rdv, 32'h0003_0080);
    apb(1'b1, CMF_OFS_CTRL, 32'h0);
    chk("dir locked", 32'(dir), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'(errv), 32'h1);
    chk("unmapped data", rdv, 32'h0);
    @(posedge sys_clk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    chk("dir reset", 32'(dir), 32'h0);
    chk("idx reset", 32'(eidx), 32'h0);
    chk("accept reset", 32'(rx_acc), 32'h1);
    arst_n_in <= 1'b1;
    apb(1'b0, CMF_OFS_IRQ, 32'h0);
    chk("irq rereset", rdv, 32'h0);
    summarize();
  end
endmodule // tb_top
bind cmf_queue_status cmf_queue_props #(.IDX_W(IDX_W)) u_props (
  .sys_clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .prdata_out, .engine_rx_store_in, .engine_tx_sent_in,
  .engine_slot_index_out, .queue_direction_sel_out, .queue_depth_field_out,
  .rx_accept_out, .tx_pending_out);
